// [core/serial_session_error_coder.sv]
// Reply checker: waits for one expected reply, classifies faults into minor codes.
// Assumes the receive framer and check-code unit run on i_sys_clk.
// Overview of operation
// - New attach: parity 40h, framing 41h, check 42h
// - New attach: type 43h, next 44h, code 45h
// - New attach timeout: resend twice, then 46h
// - Re-attach: parity 50h, framing 51h, check 52h
// - Re-attach: type 53h, next 54h, code 55h
// - Re-attach timeout after two resends: 56h
// - Final reply: parity 60h, framing 61h, check 62h
// - Final reply: type 63h, next 64h, code 65h
// - Final reply timeout reports 66h
// - Intermediate: parity 70h, framing 71h, check 72h
// - Intermediate: type 73h, next 74h, code 75h
// - Intermediate reply timeout reports 76h
// - Attach fault leaves session not connected
// - All faults use major code 12
// - Reply code must equal request plus 80h
`timescale 1ns/1ps
module serial_session_error_coder
  import reply_check_pkg::*;
#(
  parameter int TIMEOUT_CYC = REPLY_TIMEOUT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_expect,
  input wire reply_kind_e i_kind,
  input wire logic [7:0] i_request_code,
  input wire logic i_reply_valid,
  input wire logic i_parity_err,
  input wire logic i_framing_err,
  input wire logic i_overrun_err,
  input wire logic [7:0] i_block_check_value,
  input wire logic [7:0] i_block_check_calc,
  input wire logic i_msg_type_ok,
  input wire logic i_next_type_ok,
  input wire logic [7:0] i_reply_code,
  output logic o_resend,
  output logic o_done,
  output logic o_fault,
  output logic [7:0] o_major,
  output logic [7:0] o_minor,
  output logic o_connected
);

  typedef struct packed {
    check_state_e state;
    reply_kind_e kind;
    logic [7:0] req_code;
    logic [31:0] timer;
    logic [1:0] resends;
    logic resend;
    logic done;
    logic fault;
    logic [7:0] major;
    logic [7:0] minor;
    logic connected;
  } regs_s;

  regs_s r;
  regs_s next_r;

  function automatic logic [7:0] base_of(input reply_kind_e k);
    case (k)
      KIND_NEW_ATTACH: base_of = BASE_NEW_ATTACH;
      KIND_RE_ATTACH: base_of = BASE_RE_ATTACH;
      KIND_FINAL: base_of = BASE_FINAL;
      default: base_of = BASE_INTERMEDIATE;
    endcase
  endfunction

  function automatic logic is_attach(input reply_kind_e k);
    is_attach = (k == KIND_NEW_ATTACH) || (k == KIND_RE_ATTACH);
  endfunction

  logic has_fault;
  logic [3:0] fault_sel;

  // Priority: character faults, then check value, then content checks
  always_comb begin
    has_fault = 1'b1;
    fault_sel = FAULT_PARITY;
    if (i_parity_err) begin
      fault_sel = FAULT_PARITY;
    end else if (i_framing_err || i_overrun_err) begin
      fault_sel = FAULT_FRAMING;
    end else if (i_block_check_value != i_block_check_calc) begin
      fault_sel = FAULT_CHECK;
    end else if (!i_msg_type_ok) begin
      fault_sel = FAULT_MSG_TYPE;
    end else if (!i_next_type_ok) begin
      fault_sel = FAULT_NEXT_TYPE;
    end else if (i_reply_code != 8'(r.req_code + REPLY_CODE_OFFSET)) begin
      fault_sel = FAULT_REPLY_CODE;
    end else begin
      has_fault = 1'b0;
    end
  end

  always_comb begin
    next_r = r;
    next_r.resend = 1'b0;
    next_r.done = 1'b0;
    case (r.state)
      ST_IDLE: begin
        if (i_expect) begin
          next_r.state = ST_WAIT;
          next_r.kind = i_kind;
          next_r.req_code = i_request_code;
          next_r.timer = 32'h0;
          next_r.resends = 2'h0;
          next_r.fault = 1'b0;
          next_r.minor = 8'h00;
          if (is_attach(i_kind)) begin
            next_r.connected = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        if (i_reply_valid) begin
          next_r.state = ST_DONE;
          next_r.done = 1'b1;
          next_r.fault = has_fault;
          next_r.minor = has_fault ? (base_of(r.kind) | {4'h0, fault_sel}) : 8'h00;
          next_r.major = MAJOR_CODE;
          if (is_attach(r.kind)) begin
            next_r.connected = !has_fault;
          end
        end else if (r.timer == 32'(TIMEOUT_CYC - 1)) begin
          next_r.timer = 32'h0;
          if (is_attach(r.kind) && r.resends != 2'(ATTACH_RESENDS)) begin
            next_r.resends = r.resends + 2'h1;
            next_r.resend = 1'b1;
          end else begin
            next_r.state = ST_DONE;
            next_r.done = 1'b1;
            next_r.fault = 1'b1;
            next_r.minor = base_of(r.kind) | {4'h0, FAULT_TIMEOUT};
            next_r.major = MAJOR_CODE;
            if (is_attach(r.kind)) begin
              next_r.connected = 1'b0;
            end
          end
        end else begin
          next_r.timer = r.timer + 32'h1;
        end
      end
      ST_DONE: begin
        if (!i_expect) begin
          next_r.state = ST_IDLE;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.major <= MAJOR_CODE;
    end else begin
      r <= next_r;
    end
  end

  assign o_resend = r.resend;
  assign o_done = r.done;
  assign o_fault = r.fault;
  assign o_major = r.major;
  assign o_minor = r.minor;
  assign o_connected = r.connected;

  // Helper terms for the checks below, written from the inputs rather than from the decoder
  logic take_reply;
  logic chars_clean;
  logic last_tick;
  assign take_reply = (r.state == ST_WAIT) && i_reply_valid;
  assign chars_clean = !i_parity_err && !i_framing_err && !i_overrun_err
    && (i_block_check_value == i_block_check_calc);
  assign last_tick = (r.state == ST_WAIT) && !i_reply_valid && (r.timer == 32'(TIMEOUT_CYC - 1));

  property p_major_fixed;
    @(posedge i_sys_clk) disable iff (i_sys_rst) o_done |-> o_major == 8'h0c;
  endproperty
  a_major_fixed: assert property (p_major_fixed) else $error("major code not 12");

  property p_attach_fault_disconnects;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (o_done && o_fault && (o_minor[7:4] == 4'h4 || o_minor[7:4] == 4'h5)) |-> !o_connected;
  endproperty
  a_attach_fault_disconnects: assert property (p_attach_fault_disconnects) else $error("connected after fault");

  property p_parity_first;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (r.state == ST_WAIT && i_reply_valid && i_parity_err && r.kind == KIND_FINAL) |=> o_minor == 8'h60;
  endproperty
  a_parity_first: assert property (p_parity_first) else $error("parity not 60h");

  property p_new_framing;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (r.state == ST_WAIT && i_reply_valid && !i_parity_err && i_overrun_err && r.kind == KIND_NEW_ATTACH)
      |=> o_minor == 8'h41 && !o_connected;
  endproperty
  a_new_framing: assert property (p_new_framing) else $error("framing not 41h");

  property p_reattach_check;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (r.state == ST_WAIT && i_reply_valid && !i_parity_err && !i_framing_err && !i_overrun_err
       && i_block_check_value != i_block_check_calc && r.kind == KIND_RE_ATTACH) |=> o_minor == 8'h52;
  endproperty
  a_reattach_check: assert property (p_reattach_check) else $error("check fault not 52h");

  property p_reply_code;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (take_reply && chars_clean && i_msg_type_ok && i_next_type_ok && i_reply_code == 8'(r.req_code + 8'h80))
      |=> !o_fault && o_minor == 8'h00;
  endproperty
  a_reply_code: assert property (p_reply_code) else $error("good reply flagged");

  property p_interm_type;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (take_reply && chars_clean && !i_msg_type_ok && r.kind == KIND_INTERMEDIATE) |=> o_minor == 8'h73;
  endproperty
  a_interm_type: assert property (p_interm_type) else $error("type fault not 73h");

  property p_timeout_code;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (o_done && o_fault && o_minor[3:0] == 4'h6) |-> (o_minor[7:4] < 4'h6 ? r.resends == 2'h2 : 1'b1);
  endproperty
  a_timeout_code: assert property (p_timeout_code) else $error("timeout before two resends");

  property p_resend_only_attach;
    @(posedge i_sys_clk) disable iff (i_sys_rst) o_resend |-> is_attach(r.kind) && r.resends != 2'h0;
  endproperty
  a_resend_only_attach: assert property (p_resend_only_attach) else $error("bad resend");

  property p_new_next_type;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (take_reply && chars_clean && i_msg_type_ok && !i_next_type_ok && r.kind == KIND_NEW_ATTACH)
      |=> o_minor == 8'h44 && !o_connected;
  endproperty
  a_new_next_type: assert property (p_new_next_type) else $error("next type fault not 44h");

  property p_reattach_code;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (take_reply && chars_clean && i_msg_type_ok && i_next_type_ok && r.kind == KIND_RE_ATTACH
       && i_reply_code != 8'(r.req_code + 8'h80)) |=> o_minor == 8'h55 && !o_connected;
  endproperty
  a_reattach_code: assert property (p_reattach_code) else $error("reply code fault not 55h");

  property p_final_framing;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (take_reply && !i_parity_err && i_framing_err && r.kind == KIND_FINAL) |=> o_minor == 8'h61;
  endproperty
  a_final_framing: assert property (p_final_framing) else $error("framing not 61h");

  property p_final_code;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (take_reply && chars_clean && i_msg_type_ok && i_next_type_ok && r.kind == KIND_FINAL
       && i_reply_code != 8'(r.req_code + 8'h80)) |=> o_fault && o_minor == 8'h65;
  endproperty
  a_final_code: assert property (p_final_code) else $error("reply code fault not 65h");

  property p_interm_parity;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (take_reply && i_parity_err && r.kind == KIND_INTERMEDIATE) |=> o_minor == 8'h70;
  endproperty
  a_interm_parity: assert property (p_interm_parity) else $error("parity not 70h");

  property p_new_timeout;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (last_tick && r.kind == KIND_NEW_ATTACH && r.resends == 2'h2)
      |=> o_done && o_minor == 8'h46 && !o_connected;
  endproperty
  a_new_timeout: assert property (p_new_timeout) else $error("timeout not 46h");

  property p_reattach_timeout;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (last_tick && r.kind == KIND_RE_ATTACH && r.resends == 2'h2)
      |=> o_done && o_minor == 8'h56 && !o_connected;
  endproperty
  a_reattach_timeout: assert property (p_reattach_timeout) else $error("timeout not 56h");

  property p_final_timeout;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (last_tick && r.kind == KIND_FINAL) |=> o_done && o_fault && o_minor == 8'h66 && !o_resend;
  endproperty
  a_final_timeout: assert property (p_final_timeout) else $error("timeout not 66h");

  property p_interm_timeout;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (last_tick && r.kind == KIND_INTERMEDIATE) |=> o_done && o_fault && o_minor == 8'h76 && !o_resend;
  endproperty
  a_interm_timeout: assert property (p_interm_timeout) else $error("timeout not 76h");

  property p_early_resend;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (last_tick && is_attach(r.kind) && r.resends != 2'h2) |=> o_resend && !o_done;
  endproperty
  a_early_resend: assert property (p_early_resend) else $error("attach not resent");

  property p_check_before_type;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (take_reply && !i_parity_err && !i_framing_err && !i_overrun_err && !i_msg_type_ok && r.kind == KIND_FINAL
       && i_block_check_value != i_block_check_calc) |=> o_minor == 8'h62;
  endproperty
  a_check_before_type: assert property (p_check_before_type) else $error("check fault not 62h");

  property p_done_holds;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (r.state == ST_DONE && i_expect) |=> !o_done && $stable(o_minor) && $stable(o_fault);
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("result changed while held");

  property p_final_keeps_link;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (r.state == ST_WAIT && !is_attach(r.kind)) |=> $stable(o_connected);
  endproperty
  a_final_keeps_link: assert property (p_final_keeps_link) else $error("link state changed");

endmodule // serial_session_error_coder

// [core/reply_check_pkg.sv]
// Constants for the reply checker of a serial request/response master.
// Assumes a single 40 MHz system clock domain.
package reply_check_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int REPLY_TIMEOUT_MS = 100;
  localparam int REPLY_TIMEOUT_CYC = (CLK_HZ / 1000) * REPLY_TIMEOUT_MS;
  localparam int ATTACH_RESENDS = 2;
  localparam logic [7:0] MAJOR_CODE = 8'h0c;
  localparam logic [7:0] REPLY_CODE_OFFSET = 8'h80;
  // Minor code bases per reply kind; low nibble selects the fault
  localparam logic [7:0] BASE_NEW_ATTACH = 8'h40;
  localparam logic [7:0] BASE_RE_ATTACH = 8'h50;
  localparam logic [7:0] BASE_FINAL = 8'h60;
  localparam logic [7:0] BASE_INTERMEDIATE = 8'h70;
  localparam logic [3:0] FAULT_PARITY = 4'h0;
  localparam logic [3:0] FAULT_FRAMING = 4'h1;
  localparam logic [3:0] FAULT_CHECK = 4'h2;
  localparam logic [3:0] FAULT_MSG_TYPE = 4'h3;
  localparam logic [3:0] FAULT_NEXT_TYPE = 4'h4;
  localparam logic [3:0] FAULT_REPLY_CODE = 4'h5;
  localparam logic [3:0] FAULT_TIMEOUT = 4'h6;
  typedef enum logic [1:0] {
    KIND_NEW_ATTACH = 2'h0,
    KIND_RE_ATTACH = 2'h1,
    KIND_FINAL = 2'h2,
    KIND_INTERMEDIATE = 2'h3
  } reply_kind_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } check_state_e;
endpackage

// [testbench/reply_slave_model.sv]
// Behavioural remote slave: answers one request after a delay, with chosen faults.
// Assumes the bench pulses i_go for one cycle, changed on the falling edge.
`timescale 1ns/1ps
module reply_slave_model (
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic [3:0] i_delay,
  input wire logic [6:0] i_mask,
  input wire logic [7:0] i_request_code,
  output logic o_reply_valid,
  output logic o_parity_err,
  output logic o_framing_err,
  output logic o_overrun_err,
  output logic [7:0] o_block_check_value,
  output logic [7:0] o_block_check_calc,
  output logic o_msg_type_ok,
  output logic o_next_type_ok,
  output logic [7:0] o_reply_code
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] pat = 8'h00;
  logic [6:0] m = 7'h00;
  logic [7:0] req = 8'h00;
  initial o_reply_valid = 1'b0;
  always @(posedge i_sys_clk) begin
    o_reply_valid <= 1'b0;
    pat <= pat + 8'h3b;
    if (i_go) begin
      cnt <= i_delay;
      m <= i_mask;
      req <= i_request_code;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      o_reply_valid <= (cnt == 4'h1);
    end
  end
  // Outside the reply cycle every field carries a moving pattern
  assign o_parity_err = o_reply_valid ? m[0] : pat[0];
  assign o_framing_err = o_reply_valid ? m[1] : pat[1];
  assign o_overrun_err = o_reply_valid ? m[2] : pat[2];
  assign o_block_check_value = o_reply_valid ? (pat ^ {7'h00, m[3]}) : ~pat;
  assign o_block_check_calc = pat;
  assign o_msg_type_ok = o_reply_valid ? ~m[4] : pat[3];
  assign o_next_type_ok = o_reply_valid ? ~m[5] : pat[4];
  assign o_reply_code = o_reply_valid ? (req + 8'h80 + {7'h00, m[6]}) : pat;
endmodule // reply_slave_model

// [testbench/serial_session_error_coder_tb.sv]
// Self-checking bench for the reply fault coder, with a behavioural slave.
// Assumes the reply timeout parameter is shortened to 20 cycles.
`timescale 1ns/1ps
module serial_session_error_coder_tb;
  import reply_check_pkg::*;
  logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_expect = 1'b0, go = 1'b0;
  reply_kind_e i_kind = KIND_NEW_ATTACH;
  logic [7:0] i_request_code = 8'h00, i_block_check_value, i_block_check_calc, i_reply_code, o_major, o_minor;
  logic [3:0] dly = 4'h1;
  logic [6:0] mask = 7'h00;
  logic i_reply_valid, i_parity_err, i_framing_err, i_overrun_err, i_msg_type_ok, i_next_type_ok;
  logic o_resend, o_done, o_fault, o_connected, conn_exp = 1'b0;
  int err_total = 0, checks_done = 0, nres;
  serial_session_error_coder #(.TIMEOUT_CYC(20)) dut (.i_sys_clk, .i_sys_rst, .i_expect, .i_kind,
    .i_request_code, .i_reply_valid, .i_parity_err, .i_framing_err, .i_overrun_err, .i_block_check_value,
    .i_block_check_calc, .i_msg_type_ok, .i_next_type_ok, .i_reply_code, .o_resend, .o_done, .o_fault,
    .o_major, .o_minor, .o_connected);
  reply_slave_model slave (.i_sys_clk, .i_go(go), .i_delay(dly), .i_mask(mask), .i_request_code,
    .o_reply_valid(i_reply_valid), .o_parity_err(i_parity_err), .o_framing_err(i_framing_err),
    .o_overrun_err(i_overrun_err), .o_block_check_value(i_block_check_value),
    .o_block_check_calc(i_block_check_calc), .o_msg_type_ok(i_msg_type_ok),
    .o_next_type_ok(i_next_type_ok), .o_reply_code(i_reply_code));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  // Single minor code: character faults, then check code, then types and reply code
  function automatic logic [7:0] exp_minor(input reply_kind_e k, input logic [6:0] mk, input bit to);
    logic [3:0] f;
    f = to ? FAULT_TIMEOUT : mk[0] ? FAULT_PARITY : |mk[2:1] ? FAULT_FRAMING : mk[3] ? FAULT_CHECK :
      mk[4] ? FAULT_MSG_TYPE : mk[5] ? FAULT_NEXT_TYPE : FAULT_REPLY_CODE;
    return (!to && mk == 7'h00) ? 8'h00 : (8'h40 + {2'b00, k, 4'h0} + {4'h0, f});
  endfunction
  task automatic run(input reply_kind_e k, input logic [6:0] mk, input bit to);
    int n;
    nres = 0;
    @(negedge i_sys_clk);
    i_kind = k;
    i_request_code = 8'($urandom);
    mask = mk;
    dly = 4'h1 + 4'($urandom % 15);
    i_expect = 1'b1;
    go = !to;
    @(negedge i_sys_clk);
    go = 1'b0;
    for (n = 0; n < 200 && o_done !== 1'b1; n++) begin
      nres += (o_resend === 1'b1);
      @(negedge i_sys_clk);
    end
    if (k == KIND_NEW_ATTACH || k == KIND_RE_ATTACH) conn_exp = !to && mk == 7'h00;
    check({7'h00, o_done}, 8'h01, "done");
    check(o_minor, exp_minor(k, mk, to), "minor");
    check(o_major, 8'h0c, "major");
    check({7'h00, o_fault}, {7'h00, exp_minor(k, mk, to) != 8'h00}, "fault");
    check({7'h00, o_connected}, {7'h00, conn_exp}, "connected");
    check(8'(nres), (to && (k == KIND_NEW_ATTACH || k == KIND_RE_ATTACH)) ? 8'h02 : 8'h00, "resends");
    i_expect = 1'b0;
    repeat (2) @(negedge i_sys_clk);
  endtask
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (30000) @(posedge i_sys_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    void'($urandom(48));
    repeat (12) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    check(o_major, 8'h0c, "major after reset");
    check(o_minor, 8'h00, "minor after reset");
    for (int k = 0; k < 4; k++) begin
      run(reply_kind_e'(k), 7'h00, 1'b0);
      for (int b = 0; b < 7; b++) run(reply_kind_e'(k), 7'h01 << b, 1'b0);
      run(reply_kind_e'(k), 7'h00, 1'b1);
      run(reply_kind_e'(k), 7'h00, 1'b0);
      $display("test kind %0d done", k);
    end
    repeat (40) run(reply_kind_e'($urandom % 4), 7'($urandom), 1'b0);
    $display("test random faults done");
    report_and_stop();
  end
endmodule // serial_session_error_coder_tb
